/* include/epc_defines.svh */
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

// Timing in ns and derived cycle counts at 100 MHz
`define EPC_CLK_PERIOD_NS   10
`define EPC_ADDRESS_ACCESS_TIME_NS         200
`define EPC_TOE_NS          50
`define EPC_TDF_NS          60
`define EPC_SETUP_NS        1000
`define EPC_PULSE_NS        100000
`define EPC_ADDRESS_ACCESS_TIME_CYC        ((`EPC_ADDRESS_ACCESS_TIME_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_TOE_CYC         ((`EPC_TOE_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_GATE_DLY_CYC    ((`EPC_ADDRESS_ACCESS_TIME_NS - `EPC_TOE_NS) / `EPC_CLK_PERIOD_NS)
`define EPC_TDF_CYC         ((`EPC_TDF_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_SETUP_CYC       ((`EPC_SETUP_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_PULSE_CYC       (`EPC_PULSE_NS / `EPC_CLK_PERIOD_NS)
`define EPC_MAX_PULSES      25
`define EPC_ERASED_BYTE     8'hff

`endif

/* include/epc_pkg.sv */
package epc_pkg;

  typedef enum logic [2:0] {
    EPC_OP_NONE,
    EPC_OP_READ,
    EPC_OP_PROG,
    EPC_OP_PWR_UP,
    EPC_OP_PWR_DN
  } epc_op_e;

  typedef struct packed {
    epc_op_e     op;
    logic [13:0] addr;
    logic [7:0]  data;
  } epc_req_s;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic [7:0] data;
    logic [4:0] pulses;
  } epc_rsp_s;

  typedef struct packed {
    logic select_n;
    logic gate_n;
    logic program_strobe_n;
    logic vcc_prog;
    logic vpp_prog;
  } epc_ctl_s;

endpackage

/* rtl/epc_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module epc_timer #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  output logic              expired
);

  logic [W-1:0] cnt_r;
  logic         run_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      // Minus one so a count of N waits exactly N cycles
      cnt_r <= count - 1'b1;
      run_r <= 1'b1;
    end else if (run_r && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      run_r <= 1'b0;
    end
  end

  // No start term: callers reload from expired, which would loop
  assign expired = run_r && (cnt_r == '0);

endmodule

`default_nettype wire

/* rtl/epc_ctrl.sv */
// Operation
// - Select chooses and powers the device; gate only enables outputs.
// - Gate may lag select by access time minus output enable time.
// - Programming supply high level in programming, normal otherwise; the code holds it high from power-up to power-down, reads included.
// - Core supply raised in programming, normal otherwise; the code holds it raised from power-up to power-down, reads included.
// - Core supply on before programming supply, off after it.
// - Program strobe high before programming supply is applied.
// - Program: supply raised, select low, gate high, data driven.
// - Repeat 100 us strobes with verify, at most 25 per byte.
`timescale 1ns/1ps
`default_nettype none
`include "epc_defines.svh"

module epc_ctrl #(
  parameter int AW          = 14,
  parameter int DW          = 8,
  parameter int MAX_PULSES  = `EPC_MAX_PULSES,
  parameter int PULSE_CYC   = `EPC_PULSE_CYC,
  parameter int SETUP_CYC   = `EPC_SETUP_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // User request and answer
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire epc_pkg::epc_req_s req,
  output epc_pkg::epc_rsp_s      rsp,
  output logic                   powered,
  // Device pins
  output logic [AW-1:0]          mem_addr,
  output logic [DW-1:0]          mem_data_o,
  output logic                   mem_data_oe,
  input  wire logic [DW-1:0]     mem_data_i,
  output epc_pkg::epc_ctl_s      mem_ctl
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0] {
    EPC_IDLE, EPC_RD_SEL, EPC_RD_GATE, EPC_RD_FLOAT,
    EPC_PU_VCC, EPC_PU_VPP, EPC_PD_VPP, EPC_PD_VCC,
    EPC_PG_SETUP, EPC_PG_PULSE, EPC_PG_HOLD, EPC_PG_VERIFY, EPC_PG_FLOAT
  } epc_state_e;

  epc_state_e        state_r;
  epc_pkg::epc_ctl_s ctl_r;
  logic [AW-1:0]     addr_r;
  logic [DW-1:0]     data_r;
  logic              data_oe_r;
  logic [4:0]        pulses_r;
  logic              powered_r;
  epc_pkg::epc_rsp_s rsp_r;
  logic [DW-1:0]     sync1_r;
  logic [DW-1:0]     sync2_r;

  logic              t_start;
  logic [16:0]       t_count;
  logic              t_exp;

  epc_timer #(.W(17)) u_timer (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .start   (t_start),
    .count   (t_count),
    .expired (t_exp)
  );

  localparam logic [16:0] GATE_DLY = 17'(`EPC_GATE_DLY_CYC);
  localparam logic [16:0] OE_DLY   = 17'(`EPC_TOE_CYC + 2);
  localparam logic [16:0] DF_DLY   = 17'(`EPC_TDF_CYC);
  localparam logic [16:0] SU_DLY   = 17'(SETUP_CYC);
  localparam logic [16:0] PW_DLY   = 17'(PULSE_CYC);
  localparam logic [4:0]  MAXP     = 5'(MAX_PULSES);

  // ****************************************
  // Data input synchroniser
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= mem_data_i;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign req_ready = (state_r == EPC_IDLE);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= EPC_IDLE;
      ctl_r     <= '{select_n: 1'b1, gate_n: 1'b1, program_strobe_n: 1'b1,
                     vcc_prog: 1'b0, vpp_prog: 1'b0};
      addr_r    <= '0;
      data_r    <= '0;
      data_oe_r <= 1'b0;
      pulses_r  <= '0;
      powered_r <= 1'b0;
      rsp_r     <= '0;
    end else begin
      rsp_r.done <= 1'b0;
      case (state_r)
        EPC_IDLE: begin
          if (req_valid) begin
            addr_r   <= req.addr;
            data_r   <= req.data;
            pulses_r <= '0;
            rsp_r    <= '0;
            case (req.op)
              epc_pkg::EPC_OP_READ: begin
                ctl_r.select_n <= 1'b0;
                state_r        <= EPC_RD_SEL;
              end
              epc_pkg::EPC_OP_PWR_UP: begin
                ctl_r.program_strobe_n <= 1'b1;
                ctl_r.vcc_prog         <= 1'b1;
                state_r                <= EPC_PU_VCC;
              end
              epc_pkg::EPC_OP_PWR_DN: begin
                ctl_r.vpp_prog <= 1'b0;
                state_r        <= EPC_PD_VPP;
              end
              epc_pkg::EPC_OP_PROG: begin
                if (powered_r && ctl_r.program_strobe_n) begin
                  ctl_r.gate_n   <= 1'b1;
                  ctl_r.select_n <= 1'b0;
                  data_oe_r      <= 1'b1;
                  state_r        <= EPC_PG_SETUP;
                end else begin
                  rsp_r.done <= 1'b1;
                  rsp_r.fail <= 1'b1;
                end
              end
              default: rsp_r.done <= 1'b1;
            endcase
          end
        end
        EPC_RD_SEL: if (t_exp) begin
          ctl_r.gate_n <= 1'b0;
          state_r      <= EPC_RD_GATE;
        end
        EPC_RD_GATE: if (t_exp) begin
          rsp_r.data   <= sync2_r;
          ctl_r.gate_n <= 1'b1;
          state_r      <= EPC_RD_FLOAT;
        end
        EPC_RD_FLOAT: if (t_exp) begin
          ctl_r.select_n <= 1'b1;
          rsp_r.done     <= 1'b1;
          state_r        <= EPC_IDLE;
        end
        EPC_PU_VCC: if (t_exp) begin
          ctl_r.vpp_prog <= 1'b1;
          state_r        <= EPC_PU_VPP;
        end
        EPC_PU_VPP: if (t_exp) begin
          powered_r  <= 1'b1;
          rsp_r.done <= 1'b1;
          state_r    <= EPC_IDLE;
        end
        EPC_PD_VPP: if (t_exp) begin
          powered_r      <= 1'b0;
          ctl_r.vcc_prog <= 1'b0;
          state_r        <= EPC_PD_VCC;
        end
        EPC_PD_VCC: if (t_exp) begin
          rsp_r.done <= 1'b1;
          state_r    <= EPC_IDLE;
        end
        EPC_PG_SETUP: if (t_exp) begin
          ctl_r.program_strobe_n <= 1'b0;
          pulses_r               <= pulses_r + 5'd1;
          state_r                <= EPC_PG_PULSE;
        end
        EPC_PG_PULSE: if (t_exp) begin
          ctl_r.program_strobe_n <= 1'b1;
          state_r                <= EPC_PG_HOLD;
        end
        EPC_PG_HOLD: if (t_exp) begin
          data_oe_r    <= 1'b0;
          ctl_r.gate_n <= 1'b0;
          state_r      <= EPC_PG_VERIFY;
        end
        EPC_PG_VERIFY: if (t_exp) begin
          ctl_r.gate_n <= 1'b1;
          rsp_r.data   <= sync2_r;
          state_r      <= EPC_PG_FLOAT;
        end
        EPC_PG_FLOAT: if (t_exp) begin
          if (rsp_r.data == data_r || pulses_r >= MAXP) begin
            ctl_r.select_n <= 1'b1;
            rsp_r.fail     <= (rsp_r.data != data_r);
            rsp_r.pulses   <= pulses_r;
            rsp_r.done     <= 1'b1;
            state_r        <= EPC_IDLE;
          end else begin
            data_oe_r <= 1'b1;
            state_r   <= EPC_PG_SETUP;
          end
        end
        default: state_r <= EPC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Timer loads
  // ****************************************
  always_comb begin
    t_start = 1'b0;
    t_count = '0;
    case (state_r)
      EPC_IDLE: begin
        t_start = req_valid;
        t_count = (req.op == epc_pkg::EPC_OP_READ) ? GATE_DLY : SU_DLY;
      end
      EPC_RD_SEL:    begin t_start = t_exp; t_count = OE_DLY; end
      EPC_RD_GATE:   begin t_start = t_exp; t_count = DF_DLY; end
      EPC_PU_VCC:    begin t_start = t_exp; t_count = SU_DLY; end
      EPC_PD_VPP:    begin t_start = t_exp; t_count = SU_DLY; end
      EPC_PG_SETUP:  begin t_start = t_exp; t_count = PW_DLY; end
      EPC_PG_PULSE:  begin t_start = t_exp; t_count = SU_DLY; end
      EPC_PG_HOLD:   begin t_start = t_exp; t_count = OE_DLY; end
      EPC_PG_VERIFY: begin t_start = t_exp; t_count = DF_DLY; end
      EPC_PG_FLOAT:  begin t_start = t_exp; t_count = SU_DLY; end
      default: begin
        t_start = 1'b0;
        t_count = '0;
      end
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Data bus only driven with gate high, device floats then
  assign mem_addr    = addr_r;
  assign mem_data_o  = data_r;
  assign mem_data_oe = data_oe_r;
  assign mem_ctl     = ctl_r;
  assign rsp         = rsp_r;
  assign powered     = powered_r;

endmodule

`default_nettype wire

/* dv/epc_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// *****
// Controller pin checks
// *****
module epc_chk #(
  parameter int PULSE_CYC  = 10000,
  parameter int MAX_PULSES = 25
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Observed outputs
  input wire epc_pkg::epc_rsp_s rsp,
  input wire logic              mem_data_oe,
  input wire epc_pkg::epc_ctl_s mem_ctl
);
  logic [15:0] low_cnt;

  // Counter, since pulse width is far past a repetition
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_cnt <= '0;
    else if (mem_ctl.program_strobe_n) low_cnt <= '0;
    else low_cnt <= low_cnt + 16'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_vcc_first;
    $rose(mem_ctl.vpp_prog) |-> $past(mem_ctl.vcc_prog);
  endproperty
  a_vcc_first: assert property (p_vcc_first)
    else $error("programming supply rose before core");
  property p_vcc_last;
    $fell(mem_ctl.vcc_prog) |-> !$past(mem_ctl.vpp_prog);
  endproperty
  a_vcc_last: assert property (p_vcc_last)
    else $error("core supply dropped before programming supply");
  property p_vpp_vcc;
    mem_ctl.vpp_prog |-> mem_ctl.vcc_prog;
  endproperty
  a_vpp_vcc: assert property (p_vpp_vcc)
    else $error("programming supply up without core");
  property p_strobe_before;
    $rose(mem_ctl.vpp_prog) |-> mem_ctl.program_strobe_n && $past(mem_ctl.program_strobe_n);
  endproperty
  a_strobe_before: assert property (p_strobe_before)
    else $error("strobe low when programming supply rose");
  property p_strobe_powered;
    !mem_ctl.program_strobe_n |-> mem_ctl.vpp_prog && mem_ctl.vcc_prog;
  endproperty
  a_strobe_powered: assert property (p_strobe_powered)
    else $error("strobe without programming supplies");
  property p_prog_pins;
    !mem_ctl.program_strobe_n |-> !mem_ctl.select_n && mem_ctl.gate_n && mem_data_oe;
  endproperty
  a_prog_pins: assert property (p_prog_pins)
    else $error("strobe with wrong select, gate or data");
  property p_pulse_width;
    $rose(mem_ctl.program_strobe_n) |-> low_cnt == PULSE_CYC;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("strobe width wrong");
  property p_pulse_limit;
    rsp.done |-> rsp.pulses <= MAX_PULSES;
  endproperty
  a_pulse_limit: assert property (p_pulse_limit)
    else $error("too many strobes");
  property p_gate_select;
    !mem_ctl.gate_n |-> !mem_ctl.select_n && !mem_data_oe;
  endproperty
  a_gate_select: assert property (p_gate_select)
    else $error("gate low while unselected or host driving");
  property p_gate_lag;
    $fell(mem_ctl.select_n) && !mem_data_oe && !mem_ctl.vpp_prog |-> ##[1:15] $fell(mem_ctl.gate_n);
  endproperty
  a_gate_lag: assert property (p_gate_lag)
    else $error("gate lagged select too long");
endmodule

bind epc_ctrl epc_chk #(.PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .rsp(rsp), .mem_data_oe(mem_data_oe), .mem_ctl(mem_ctl)
);
`default_nettype wire

/* dv/epc_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
// *****
// Memory device model
// *****
module epc_rom_model #(
  parameter int ACC_NS = 150
) (
  // Pins
  input  wire logic [13:0]       addr,
  input  wire logic [7:0]        din,
  input  wire epc_pkg::epc_ctl_s ctl,
  output logic [7:0]             dq,
  output logic                   dq_oe,
  // Strobes a weak cell needs
  input  wire logic [5:0]        need
);
  logic [7:0] cells [0:16383];
  int         hits = 0;

  initial foreach (cells[i]) cells[i] = 8'hff;
  assign dq_oe = !ctl.select_n && !ctl.gate_n;
  assign #ACC_NS dq = cells[addr];
  always @(negedge ctl.program_strobe_n or posedge ctl.select_n) begin
    if (ctl.select_n) begin
      hits = 0;
    end else if (!ctl.program_strobe_n && ctl.vpp_prog && ctl.vcc_prog && ctl.gate_n) begin
      hits++;
      if (hits >= need) cells[addr] = cells[addr] & din;
    end
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
// *****
// Controller bench
// *****
module testbench;
  logic              mclk = 0;
  logic              rst_n = 0;
  logic              req_valid = 0;
  logic              req_ready;
  epc_pkg::epc_req_s req = '0;
  epc_pkg::epc_rsp_s rsp;
  logic              powered;
  logic [13:0]       mem_addr;
  logic [7:0]        mem_data_o;
  logic              mem_data_oe;
  epc_pkg::epc_ctl_s mem_ctl;
  logic [7:0]        dq;
  logic              dq_oe;
  logic [7:0]        bus;
  logic [7:0]        last = 8'h00;
  logic [5:0]        need = 6'h1;
  logic [7:0]        img [logic [13:0]];
  int                n_errors = 0;
  int                check_count = 0;

  always #5 mclk = ~mclk;
  // Released bus toggles so a stale byte never passes
  assign bus = dq_oe ? dq : (mem_data_oe ? mem_data_o : ~last);
  always @(posedge mclk) last <= bus;

  epc_ctrl #(.PULSE_CYC(20), .SETUP_CYC(3)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp(rsp),
    .powered(powered), .mem_addr(mem_addr), .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe),
    .mem_data_i(bus), .mem_ctl(mem_ctl));
  epc_rom_model i_rom (.addr(mem_addr), .din(bus), .ctl(mem_ctl), .dq(dq), .dq_oe(dq_oe), .need(need));

  function automatic logic [7:0] peek(input logic [13:0] a);
    return img.exists(a) ? img[a] : 8'hff;
  endfunction

  task automatic finish_test;
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic run(input epc_pkg::epc_op_e o, input logic [13:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{op: o, addr: a, data: d};
    do @(negedge mclk); while (!req_ready && ++n < 100);
    @(posedge mclk);
    req_valid <= 1'b0;
    do @(negedge mclk); while (rsp.done !== 1'b1 && ++n < 4000);
    if (n >= 4000) begin
      n_errors++;
      finish_test();
    end
    @(posedge mclk);
  endtask

  task automatic rd(input logic [13:0] a);
    run(epc_pkg::EPC_OP_READ, a, 8'h00);
    `CHK("read data", peek(a), rsp.data)
  endtask

  task automatic prog(input logic [13:0] a, input logic [7:0] d, input logic [5:0] k);
    logic [7:0] old;
    logic       bad;
    old = peek(a);
    bad = ((old & d) != d) || k > 25;
    need <= k;
    run(epc_pkg::EPC_OP_PROG, a, d);
    img[a] = (k > 25) ? old : (old & d);
    `CHK("prog fail", bad, rsp.fail)
    `CHK("prog pulses", bad ? 5'd25 : ((old == d) ? 5'd1 : 5'(k)), rsp.pulses)
  endtask

  initial begin
    void'($urandom(32'hb15c));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    `CHK("idle pins", 5'b11100, mem_ctl)
    for (int i = 0; i < 3; i++) rd(14'($urandom));
    run(epc_pkg::EPC_OP_PROG, 14'h0010, 8'h5a);
    `CHK("unpowered prog", 1'b1, rsp.fail)
    run(epc_pkg::EPC_OP_PWR_UP, 14'h0000, 8'h00);
    `CHK("supplies up", 3'b111, {powered, mem_ctl.vcc_prog, mem_ctl.vpp_prog})
    // Idle op while powered must not strobe
    run(epc_pkg::EPC_OP_NONE, 14'h0000, 8'h00);
    `CHK("idle op pulses", 5'd0, rsp.pulses)
    // Slowest passing cell, dead cell, then ones over zeros
    prog(14'h3fff, 8'h00, 6'd25);
    prog(14'h0000, 8'h81, 6'd26);
    prog(14'h3fff, 8'hff, 6'd1);
    for (int i = 0; i < 6; i++) prog(14'($urandom), 8'($urandom), 6'($urandom_range(3, 1)));
    rd(14'h3fff);
    run(epc_pkg::EPC_OP_PWR_DN, 14'h0000, 8'h00);
    `CHK("supplies down", 6'b011100, {powered, mem_ctl})
    foreach (img[a]) rd(a);
    finish_test();
  end
endmodule
`default_nettype wire
